//--- shared/flash_pwr_pkg.sv
// Shared constants, types and timing for the flash power-state controller
package flash_pwr_pkg;

    // Opcodes handled by the power-state logic
    localparam logic [7:0] OP_WAKE_SIG = 8'hab;
    localparam logic [7:0] OP_PRECHARGE = 8'ha3;
    localparam logic [7:0] OP_WRITE_ALLOW = 8'h06;
    localparam logic [7:0] OP_DEEP_SLEEP = 8'hb9;

    // Frame layout in serial clock edges
    localparam logic [5:0] OPCODE_BITS = 6'h08;
    localparam logic [5:0] FRAME_BITS = 6'h20;
    localparam logic [5:0] OPCODE_LAST = 6'h07;
    localparam logic [2:0] SIG_LAST = 3'h7;

    // Arbitrary signature value, not taken from any part
    localparam logic [7:0] SIGNATURE_DEFAULT = 8'h5a;

    // Core clock rate
    localparam int CORE_MHZ = 50;

    // Power-up write delay (least time, rounds up)
    localparam int PUW_MS = 3;
    localparam int PUW_CYCLES = (PUW_MS * 1000 * CORE_MHZ < 1) ? 1 : PUW_MS * 1000 * CORE_MHZ;

    // Host-side select delay after supply reaches its minimum
    localparam int SELECT_DELAY_US = 10;

    // Wake and sleep-entry times (longest times, round down)
    localparam int SHORT_WAKE_NS = 3000;
    localparam int LONG_WAKE_NS = 8000;
    localparam int SLEEP_ENTRY_NS = 3000;
    localparam int SHORT_WAKE_CYC = (SHORT_WAKE_NS * CORE_MHZ / 1000 < 1) ? 1 : SHORT_WAKE_NS * CORE_MHZ / 1000;
    localparam int LONG_WAKE_CYC = (LONG_WAKE_NS * CORE_MHZ / 1000 < 1) ? 1 : LONG_WAKE_NS * CORE_MHZ / 1000;
    localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS * CORE_MHZ / 1000 < 1) ? 1 : SLEEP_ENTRY_NS * CORE_MHZ / 1000;
    localparam int TIMER_W = 16;

    typedef enum logic [2:0] {
        ST_STANDBY,
        ST_PRECHARGE,
        ST_SLEEP_ENTRY,
        ST_SLEEP,
        ST_WAKING
    } power_state_e;

    // Summary of the last frame, held stable in the link domain while deselected
    typedef struct packed {
        logic [7:0] opcode;
        logic [5:0] bits;
        logic sig_done;
        logic frame_tog;
    } frame_s;

endpackage

//--- logic/spi_link_shifter.sv
// Serial-clock domain: bit capture, opcode latch and signature shifter
`timescale 1ns/1ps
module spi_link_shifter #(
    parameter logic [7:0] SIGNATURE = flash_pwr_pkg::SIGNATURE_DEFAULT
) (
    // Link pins
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic si,
    input wire logic arst_n,
    // Core side
    input wire logic busy_level,
    output flash_pwr_pkg::frame_s frame,
    // Serial output
    output logic so,
    output logic so_oe
);
    import flash_pwr_pkg::*;

    logic frame_rst;
    logic start_reg, start_next;
    logic [5:0] bit_cnt_reg, bit_cnt_next;
    logic [7:0] shift_reg, shift_next;
    logic [7:0] opcode_reg, opcode_next;
    logic tog_reg, tog_next;
    logic busy_meta_reg, busy_sync_reg;
    logic [2:0] idx_reg, idx_next;
    logic so_reg, so_next;
    logic oe_reg, oe_next;
    logic done_reg, done_next;
    logic send;

    // Deselect ends every frame at once
    assign frame_rst = cs_n | ~arst_n;

    always_comb begin
        start_next = 1'b0;
        bit_cnt_next = bit_cnt_reg;
        shift_next = {shift_reg[6:0], si};
        opcode_next = opcode_reg;
        tog_next = tog_reg;
        if (start_reg) begin
            bit_cnt_next = 6'h01;
            tog_next = ~tog_reg;
        end else if (bit_cnt_reg != FRAME_BITS) begin
            bit_cnt_next = bit_cnt_reg + 6'h01;
        end
        if (!start_reg && bit_cnt_reg == OPCODE_LAST) begin
            opcode_next = shift_next; // RULE_05
        end
    end

    always_ff @(posedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            start_reg <= 1'b1;
        end else begin
            start_reg <= start_next;
        end
    end

    always_ff @(posedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt_reg <= 6'h00;
            shift_reg <= 8'h00;
            opcode_reg <= 8'h00;
            tog_reg <= 1'b0;
            busy_meta_reg <= 1'b0;
            busy_sync_reg <= 1'b0;
        end else begin
            bit_cnt_reg <= bit_cnt_next;
            shift_reg <= shift_next;
            opcode_reg <= opcode_next;
            tog_reg <= tog_next;
            busy_meta_reg <= busy_level;
            busy_sync_reg <= busy_meta_reg;
        end
    end

    // Signature only after opcode and three dummy bytes, and not during a write cycle
    assign send = !start_reg && bit_cnt_reg == FRAME_BITS && opcode_reg == OP_WAKE_SIG && !busy_sync_reg; // RULE_03 RULE_04

    always_comb begin
        so_next = so_reg;
        oe_next = oe_reg;
        idx_next = idx_reg;
        done_next = done_reg;
        if (!start_reg && bit_cnt_reg != FRAME_BITS) begin
            done_next = 1'b0;
        end
        if (send) begin
            so_next = SIGNATURE[SIG_LAST - idx_reg]; // RULE_06 RULE_23
            oe_next = 1'b1;
            idx_next = idx_reg + 3'h1; // RULE_07
            if (idx_reg == SIG_LAST) begin
                done_next = 1'b1;
            end
        end
    end

    always_ff @(negedge sclk or posedge frame_rst) begin
        if (frame_rst) begin
            so_reg <= 1'b0;
            oe_reg <= 1'b0;
            idx_reg <= 3'h0;
        end else begin
            so_reg <= so_next;
            oe_reg <= oe_next;
            idx_reg <= idx_next;
        end
    end

    always_ff @(negedge sclk or negedge arst_n) begin
        if (!arst_n) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= done_next;
        end
    end

    assign so = so_reg;
    assign so_oe = oe_reg;
    assign frame = '{opcode: opcode_reg, bits: bit_cnt_reg, sig_done: done_reg, frame_tog: tog_reg};

    opcode_take_a: assert property (@(posedge sclk) disable iff (frame_rst) // RULE_05
        (!start_reg && bit_cnt_reg == OPCODE_LAST) |=>
            (opcode_reg[7:1] == $past(shift_reg[6:0]) && opcode_reg[0] == $past(si)))
        else $error("opcode not captured on eighth rising edge");

    sig_msb_a: assert property (@(negedge sclk) disable iff (frame_rst) // RULE_23
        $rose(oe_reg) |-> so_reg == SIGNATURE[7])
        else $error("signature does not start with its top bit");

    sig_repeat_a: assert property (@(negedge sclk) disable iff (frame_rst) // RULE_07
        (oe_reg && $past(oe_reg, 8)) |-> so_reg == $past(so_reg, 8))
        else $error("signature byte does not repeat");

    sig_gate_a: assert property (@(negedge sclk) disable iff (frame_rst) // RULE_04
        $rose(oe_reg) |-> (!$past(busy_sync_reg) && bit_cnt_reg == FRAME_BITS))
        else $error("signature driven during write cycle or too early");
endmodule

//--- logic/flash_power_ctrl.sv
// Power-state controller: deep sleep, wake with signature, pre-charge mode, power-up write inhibit
// Overview of operation
// RULE_01: Deep sleep ignores all but wake command
// RULE_02: Wake command leaves deep sleep
// RULE_03: Signature returned in any state when idle
// RULE_04: Wake not decoded during write cycle
// RULE_05: Opcode then three dummy bytes, rising edges
// RULE_06: Signature shifted out on falling edges
// RULE_07: Extra clocks repeat signature byte
// RULE_08: Host deselects after reading signature once
// RULE_09: Deselect gives standby, instantly if awake
// RULE_10: Full read from sleep: long wake delay
// RULE_11: Early deselect still reaches standby
// RULE_12: Early deselect from sleep: short wake delay
// RULE_13: Opcode A3h plus dummies enters pre-charge
// RULE_14: ABh, 06h or B9h ends pre-charge
// RULE_15: Host may use pre-charge before fast transfers
// RULE_16: Logic held reset below write threshold
// RULE_17: Write commands refused during power-up delay
// RULE_18: Host waits select delay; reads allowed
// RULE_19: Host holds writes until both delays end
// RULE_20: Power-up in standby, write latch clear
// RULE_21: Deep sleep entered fixed delay after deselect
// RULE_22: Write-in-progress flag follows cycle activity
// RULE_23: Signature sent most significant bit first
`timescale 1ns/1ps
module flash_power_ctrl #(
    parameter int PUW_CYCLES_P = flash_pwr_pkg::PUW_CYCLES,
    parameter logic [7:0] SIGNATURE = flash_pwr_pkg::SIGNATURE_DEFAULT
) (
    // Core clock and power-on reset
    input wire logic CORE_CLK,
    input wire logic ARST_N,
    // Serial link
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic SI,
    output logic SO,
    output logic SO_OE,
    // Array engine
    input wire logic CYCLE_ACTIVE,
    input wire logic WEL_CLEAR,
    output logic CMD_VALID,
    output logic [7:0] CMD_OPCODE,
    output logic WRITE_INHIBIT,
    output logic WRITE_ENABLE_LATCH,
    output logic WIP_FLAG,
    // Power state
    output logic DEEP_SLEEP,
    output logic PRECHARGE_ACTIVE,
    output logic STANDBY_READY
);
    import flash_pwr_pkg::*;

    localparam int PUW_W = $clog2(PUW_CYCLES_P + 1);
    localparam int SLEEP_ENTRY_BOUND = SLEEP_ENTRY_CYC;

    if (PUW_CYCLES_P < 1) begin : g_puw_chk
        $error("power-up write delay must be at least one cycle");
    end
    if (LONG_WAKE_CYC >= 2 ** TIMER_W || SHORT_WAKE_CYC >= 2 ** TIMER_W || SLEEP_ENTRY_CYC >= 2 ** TIMER_W)
    begin : g_timer_chk
        $error("wake or sleep time does not fit the timer");
    end

    frame_s frame;
    logic cs_meta_reg, cs_sync_reg, cs_prev_reg;
    logic seen_tog_reg, seen_tog_next;
    logic deselect, evt, have_op, awake, op_allowed;
    power_state_e state_reg, state_next;
    logic [TIMER_W-1:0] timer_reg, timer_next;
    logic long_reg, long_next;
    logic [TIMER_W-1:0] wake_age_reg, wake_age_next;
    logic [PUW_W-1:0] puw_cnt_reg, puw_cnt_next;
    logic inhibit_reg, inhibit_next;
    logic wel_reg, wel_next;
    logic wip_reg;
    logic cmd_valid_reg, cmd_valid_next;
    logic [7:0] cmd_op_reg, cmd_op_next;
    logic sleep_reg, pre_reg, ready_reg;

    spi_link_shifter #(
        .SIGNATURE(SIGNATURE)
    ) u_link (
        .sclk(SCLK),
        .cs_n(CS_N),
        .si(SI),
        .arst_n(ARST_N),
        .busy_level(wip_reg),
        .frame(frame),
        .so(SO),
        .so_oe(SO_OE)
    );

    // Deselect crossing; frame summary is static while deselected
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cs_meta_reg <= 1'b1;
            cs_sync_reg <= 1'b1;
            cs_prev_reg <= 1'b1;
        end else begin
            cs_meta_reg <= CS_N;
            cs_sync_reg <= cs_meta_reg;
            cs_prev_reg <= cs_sync_reg;
        end
    end

    assign deselect = cs_sync_reg && !cs_prev_reg;
    // A frame with no clock edges leaves the toggle alone and is ignored
    assign evt = deselect && (frame.frame_tog != seen_tog_reg);
    assign have_op = frame.bits >= OPCODE_BITS;
    assign awake = (state_reg == ST_STANDBY) || (state_reg == ST_PRECHARGE);
    assign op_allowed = evt && have_op && !wip_reg;

    // Power state machine
    always_comb begin
        state_next = state_reg;
        timer_next = timer_reg;
        long_next = long_reg;
        unique case (state_reg)
            ST_STANDBY, ST_PRECHARGE: begin
                if (op_allowed) begin
                    if (frame.opcode == OP_WAKE_SIG || frame.opcode == OP_WRITE_ALLOW) begin
                        state_next = ST_STANDBY; // RULE_09 RULE_11 RULE_14
                    end else if (frame.opcode == OP_DEEP_SLEEP && frame.bits == OPCODE_BITS) begin
                        state_next = ST_SLEEP_ENTRY; // RULE_14 RULE_21
                        timer_next = TIMER_W'(SLEEP_ENTRY_CYC - 1);
                    end else if (frame.opcode == OP_PRECHARGE && frame.bits == FRAME_BITS) begin
                        state_next = ST_PRECHARGE; // RULE_13
                    end
                end
            end
            ST_SLEEP_ENTRY: begin
                if (timer_reg == '0) begin
                    state_next = ST_SLEEP; // RULE_21
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
            ST_SLEEP: begin
                // Only the wake command is decoded here
                if (op_allowed && frame.opcode == OP_WAKE_SIG) begin // RULE_01 RULE_04
                    state_next = ST_WAKING; // RULE_02 RULE_11
                    long_next = frame.sig_done;
                    timer_next = frame.sig_done ? TIMER_W'(LONG_WAKE_CYC - 1) : TIMER_W'(SHORT_WAKE_CYC - 1); // RULE_10 RULE_12
                end
            end
            ST_WAKING: begin
                if (timer_reg == '0) begin
                    state_next = ST_STANDBY;
                end else begin
                    timer_next = timer_reg - 1'b1;
                end
            end
        endcase
    end

    // Write latch, power-up inhibit, command forwarding
    always_comb begin
        seen_tog_next = deselect ? frame.frame_tog : seen_tog_reg;
        wake_age_next = (state_reg == ST_WAKING) ? wake_age_reg + 1'b1 : '0;
        puw_cnt_next = puw_cnt_reg;
        inhibit_next = inhibit_reg;
        if (inhibit_reg) begin
            if (puw_cnt_reg == PUW_W'(PUW_CYCLES_P - 1)) begin
                inhibit_next = 1'b0;
            end else begin
                puw_cnt_next = puw_cnt_reg + 1'b1;
            end
        end
        wel_next = wel_reg;
        if (WEL_CLEAR) begin
            wel_next = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (op_allowed && awake && !inhibit_reg && frame.opcode == OP_WRITE_ALLOW) begin
            wel_next = 1'b1; // RULE_17
        end
        cmd_valid_next = evt && have_op && awake
            && !(wip_reg && frame.opcode == OP_WAKE_SIG)
            && !(inhibit_reg && frame.opcode == OP_WRITE_ALLOW); // RULE_01 RULE_17
        cmd_op_next = cmd_valid_next ? frame.opcode : cmd_op_reg;
    end

    // Reset is the power-on indication; all state returns to standby
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= ST_STANDBY; // RULE_16 RULE_20
            timer_reg <= '0;
            long_reg <= 1'b0;
            wake_age_reg <= '0;
            seen_tog_reg <= 1'b0;
            puw_cnt_reg <= '0;
            inhibit_reg <= 1'b1; // RULE_17
            wel_reg <= 1'b0; // RULE_20
            wip_reg <= 1'b0;
            cmd_valid_reg <= 1'b0;
            cmd_op_reg <= 8'h00;
            sleep_reg <= 1'b0;
            pre_reg <= 1'b0;
            ready_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
            long_reg <= long_next;
            wake_age_reg <= wake_age_next;
            seen_tog_reg <= seen_tog_next;
            puw_cnt_reg <= puw_cnt_next;
            inhibit_reg <= inhibit_next;
            wel_reg <= wel_next;
            wip_reg <= CYCLE_ACTIVE; // RULE_22
            cmd_valid_reg <= cmd_valid_next;
            cmd_op_reg <= cmd_op_next;
            sleep_reg <= (state_next == ST_SLEEP);
            pre_reg <= (state_next == ST_PRECHARGE);
            ready_reg <= (state_next == ST_STANDBY) || (state_next == ST_PRECHARGE);
        end
    end

    assign CMD_VALID = cmd_valid_reg;
    assign CMD_OPCODE = cmd_op_reg;
    assign WRITE_INHIBIT = inhibit_reg;
    assign WRITE_ENABLE_LATCH = wel_reg;
    assign WIP_FLAG = wip_reg;
    assign DEEP_SLEEP = sleep_reg;
    assign PRECHARGE_ACTIVE = pre_reg;
    assign STANDBY_READY = ready_reg;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!ARST_N);

    sequence wake_frame;
        op_allowed && frame.opcode == OP_WAKE_SIG;
    endsequence

    sequence sleep_frame;
        op_allowed && awake && frame.opcode == OP_DEEP_SLEEP && frame.bits == OPCODE_BITS;
    endsequence

    sleep_ignore_a: assert property (state_reg == ST_SLEEP |=> !CMD_VALID) // RULE_01
        else $error("command forwarded while in deep sleep");

    wake_exit_a: assert property (state_reg == ST_SLEEP ##0 wake_frame |=> state_reg == ST_WAKING) // RULE_02
        else $error("wake command did not leave deep sleep");

    busy_hold_a: assert property ((state_reg == ST_SLEEP && evt && wip_reg) |=> state_reg == ST_SLEEP) // RULE_04
        else $error("wake decoded during write cycle");

    instant_standby_a: assert property (awake ##0 wake_frame |=> STANDBY_READY && !PRECHARGE_ACTIVE) // RULE_09
        else $error("awake wake command did not give immediate standby");

    long_wake_a: assert property ((state_reg == ST_WAKING && state_next == ST_STANDBY && long_reg) // RULE_10
        |-> wake_age_reg == TIMER_W'(LONG_WAKE_CYC - 1))
        else $error("long wake delay wrong");

    short_wake_a: assert property ((state_reg == ST_WAKING && state_next == ST_STANDBY && !long_reg) // RULE_12
        |-> wake_age_reg == TIMER_W'(SHORT_WAKE_CYC - 1))
        else $error("short wake delay wrong");

    early_standby_a: assert property ((state_reg == ST_SLEEP ##0 wake_frame ##0 !frame.sig_done) // RULE_11
        |=> (state_reg == ST_WAKING && !long_reg))
        else $error("early deselect did not start short wake");

    hpm_entry_a: assert property ((op_allowed && awake && frame.opcode == OP_PRECHARGE // RULE_13
        && frame.bits == FRAME_BITS) |=> PRECHARGE_ACTIVE)
        else $error("pre-charge mode not entered");

    hpm_exit_a: assert property ((state_reg == ST_PRECHARGE && op_allowed // RULE_14
        && (frame.opcode == OP_WAKE_SIG || frame.opcode == OP_WRITE_ALLOW
        || (frame.opcode == OP_DEEP_SLEEP && frame.bits == OPCODE_BITS))) |=> !PRECHARGE_ACTIVE)
        else $error("pre-charge mode not released");

    inhibit_wel_a: assert property (WRITE_INHIBIT |-> !WRITE_ENABLE_LATCH && !(CMD_VALID // RULE_17
        && CMD_OPCODE == OP_WRITE_ALLOW))
        else $error("write enable accepted during power-up delay");

    wip_follow_a: assert property (WIP_FLAG == $past(CYCLE_ACTIVE)) // RULE_22
        else $error("write-in-progress flag does not follow cycle");

    sleep_entry_a: assert property (sleep_frame |=> state_reg == ST_SLEEP_ENTRY ##SLEEP_ENTRY_BOUND DEEP_SLEEP) // RULE_21
        else $error("deep sleep not entered after fixed delay");
endmodule

//--- bench/spi_host_model.sv
// SPI host controller model driving select, serial clock and serial input
`timescale 1ns/1ps
module spi_host_model #(
    parameter int HALF_NS = 80
) (
    // Link pins
    output logic SCLK,
    output logic CS_N,
    output logic SI,
    input wire logic SO,
    input wire logic SO_OE
);
    logic [63:0] rx;
    logic oe_seen;

    initial begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        SI = 1'b0;
        rx = '0;
        oe_seen = 1'b0;
    end

    // Clock stands low outside frames; bits launched while clock is low
    task automatic xfer(input logic [7:0] op, input int n, input logic [31:0] dummy);
        int i;
        rx = '0;
        oe_seen = 1'b0;
        #(HALF_NS + 13);
        CS_N = 1'b0;
        for (i = 0; i < n; i++) begin
            SI = (i < 8) ? op[7 - i] : dummy[i % 32];
            #(HALF_NS);
            SCLK = 1'b1;
            if (i >= 32) begin
                rx = {rx[62:0], SO};
                oe_seen = oe_seen | SO_OE;
            end
            #(HALF_NS);
            SCLK = 1'b0;
        end
        #(HALF_NS);
        CS_N = 1'b1;
        SI = ~SI;
    endtask
endmodule

//--- bench/flash_power_ctrl_tb.sv
// Self-checking bench for the flash power-state controller
`timescale 1ns/1ps
module flash_power_ctrl_tb;
    import flash_pwr_pkg::*;
    localparam int PUW_TB = 1200;
    // Arbitrary signature value
    localparam logic [7:0] SIG_TB = 8'hc3;
    logic CORE_CLK = 1'b0;
    logic ARST_N = 1'b0;
    logic CYCLE_ACTIVE = 1'b0;
    logic WEL_CLEAR = 1'b0;
    logic SCLK, CS_N, SI, SO, SO_OE, CMD_VALID, WRITE_INHIBIT, WRITE_ENABLE_LATCH, WIP_FLAG;
    logic DEEP_SLEEP, PRECHARGE_ACTIVE, STANDBY_READY;
    logic [7:0] CMD_OPCODE;
    logic [7:0] exits [3] = '{OP_WAKE_SIG, OP_WRITE_ALLOW, OP_DEEP_SLEEP};
    int lens [3] = '{40, 36, 16};
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int cmd_cnt = 0;
    int low_cnt = 0;
    int seed = 60171;
    int c0, r0, extra, k, j, lim;

    spi_host_model i_host (.SCLK(SCLK), .CS_N(CS_N), .SI(SI), .SO(SO), .SO_OE(SO_OE));

    flash_power_ctrl #(.PUW_CYCLES_P(PUW_TB), .SIGNATURE(SIG_TB)) i_dut (
        .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .SCLK(SCLK), .CS_N(CS_N), .SI(SI), .SO(SO),
        .SO_OE(SO_OE), .CYCLE_ACTIVE(CYCLE_ACTIVE), .WEL_CLEAR(WEL_CLEAR), .CMD_VALID(CMD_VALID),
        .CMD_OPCODE(CMD_OPCODE), .WRITE_INHIBIT(WRITE_INHIBIT), .WRITE_ENABLE_LATCH(WRITE_ENABLE_LATCH),
        .WIP_FLAG(WIP_FLAG), .DEEP_SLEEP(DEEP_SLEEP), .PRECHARGE_ACTIVE(PRECHARGE_ACTIVE),
        .STANDBY_READY(STANDBY_READY)
    );

    always #10 CORE_CLK = ~CORE_CLK;

    task automatic finish_test();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    always @(posedge CORE_CLK) begin
        cycles++;
        if (CMD_VALID === 1'b1) cmd_cnt++;
        if (STANDBY_READY === 1'b0) low_cnt++;
        if (cycles == 60000) begin
            failures++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic core(input int n);
        repeat (n) @(posedge CORE_CLK);
        #1;
    endtask

    task automatic frame(input logic [7:0] op, input int n);
        i_host.xfer(op, n, $random(seed));
        core(10);
    endtask

    // Bounded waits on a design flag
    task automatic wait_ready();
        for (lim = 0; lim < 2000 && STANDBY_READY !== 1'b1; lim++) core(1);
    endtask

    task automatic wait_sleep();
        for (lim = 0; lim < 2000 && DEEP_SLEEP !== 1'b1; lim++) core(1);
    endtask

    function automatic logic [63:0] exp_rx(input int n);
        logic [63:0] r;
        int b;
        r = '0;
        for (b = 0; b < n; b++) r = {r[62:0], SIG_TB[7 - (b % 8)]};
        return r;
    endfunction

    function automatic logic in_range(input int v, input int lo, input int hi);
        return (v >= lo && v <= hi);
    endfunction

    initial begin
        core(8);
        check("inhibit_rst", WRITE_INHIBIT, 1'b1);
        check("standby_rst", STANDBY_READY, 1'b1);
        check("sleep_rst", DEEP_SLEEP, 1'b0);
        check("wel_rst", WRITE_ENABLE_LATCH, 1'b0);
        check("oe_rst", SO_OE, 1'b0);
        ARST_N = 1'b1;
        r0 = cycles;
        // Host keeps off the link for the select delay
        core(SELECT_DELAY_US * CORE_MHZ);
        c0 = cmd_cnt;
        frame(OP_WRITE_ALLOW, 8);
        check("wel_inhibit", WRITE_ENABLE_LATCH, 1'b0);
        check("cmd_inhibit", cmd_cnt - c0, 0);
        // Reads are served while writes are still held off
        frame(OP_WAKE_SIG, 40);
        check("sig_early", i_host.rx, exp_rx(8));
        check("inhibit_mid", WRITE_INHIBIT, 1'b1);
        c0 = cmd_cnt;
        for (lim = 0; lim < 400 && WRITE_INHIBIT !== 1'b0; lim++) core(1);
        check("inhibit_len", in_range(cycles - r0, PUW_TB, PUW_TB + 2), 1'b1);
        frame(OP_WRITE_ALLOW, 8);
        check("wel_set", WRITE_ENABLE_LATCH, 1'b1);
        check("cmd_fwd", cmd_cnt - c0, 1);
        check("cmd_op", CMD_OPCODE, OP_WRITE_ALLOW);
        WEL_CLEAR = 1'b1;
        core(1);
        WEL_CLEAR = 1'b0;
        check("wel_clr", WRITE_ENABLE_LATCH, 1'b0);
        for (k = 0; k < 4; k++) begin
            extra = (k == 0) ? 8 : 1 + ($random(seed) & 8'h1f);
            low_cnt = 0;
            frame(OP_WAKE_SIG, 32 + extra);
            check("sig_awake", i_host.rx, exp_rx(extra));
            check("oe_awake", i_host.oe_seen, 1'b1);
            check("oe_off", SO_OE, 1'b0);
            check("standby_now", low_cnt, 0);
        end
        for (k = 0; k < 3; k++) begin
            frame(OP_PRECHARGE, 32);
            check("pre_on", PRECHARGE_ACTIVE, 1'b1);
            low_cnt = 0;
            i_host.xfer(exits[k], (k == 2) ? 8 : 32, $random(seed));
            core(10);
            check("pre_off", PRECHARGE_ACTIVE, 1'b0);
        end
        wait_sleep();
        check("entry_len", in_range(low_cnt, SLEEP_ENTRY_CYC, SLEEP_ENTRY_CYC + 13), 1'b1);
        check("asleep", DEEP_SLEEP, 1'b1);
        c0 = cmd_cnt;
        frame(OP_WRITE_ALLOW, 8);
        frame(OP_PRECHARGE, 32);
        check("sleep_ign", cmd_cnt - c0, 0);
        check("sleep_pre", PRECHARGE_ACTIVE, 1'b0);
        check("sleep_hold", DEEP_SLEEP, 1'b1);
        for (j = 0; j < 3; j++) begin
            if (j > 0) begin
                frame(OP_DEEP_SLEEP, 8);
                wait_sleep();
            end
            i_host.xfer(OP_WAKE_SIG, lens[j], $random(seed));
            low_cnt = 0;
            wait_ready();
            check("woken", DEEP_SLEEP, 1'b0);
            if (lens[j] >= 40) begin
                check("sig_sleep", i_host.rx, exp_rx(lens[j] - 32));
                check("long_wake", in_range(low_cnt, LONG_WAKE_CYC + 2, LONG_WAKE_CYC + 4), 1'b1);
            end else begin
                check("short_wake", in_range(low_cnt, SHORT_WAKE_CYC + 2, SHORT_WAKE_CYC + 4), 1'b1);
            end
            core(4);
        end
        CYCLE_ACTIVE = 1'b1;
        core(2);
        check("wip_on", WIP_FLAG, 1'b1);
        c0 = cmd_cnt;
        frame(OP_WAKE_SIG, 40);
        check("wip_nosig", i_host.oe_seen, 1'b0);
        check("wip_nocmd", cmd_cnt - c0, 0);
        check("wip_kept", WIP_FLAG, 1'b1);
        CYCLE_ACTIVE = 1'b0;
        core(1);
        check("wip_off", WIP_FLAG, 1'b0);
        // Wake refused while asleep and busy
        frame(OP_DEEP_SLEEP, 8);
        wait_sleep();
        CYCLE_ACTIVE = 1'b1;
        core(2);
        frame(OP_WAKE_SIG, 40);
        check("wip_sleep", DEEP_SLEEP, 1'b1);
        check("wip_sleep_sig", i_host.oe_seen, 1'b0);
        // Power loss while asleep; a frame during reset is ignored
        CYCLE_ACTIVE = 1'b0;
        ARST_N = 1'b0;
        i_host.xfer(OP_WAKE_SIG, 40, $random(seed));
        core(4);
        check("por_nosig", i_host.oe_seen, 1'b0);
        check("por_rx", i_host.rx, 64'h0);
        ARST_N = 1'b1;
        core(3);
        check("pwr_standby", STANDBY_READY, 1'b1);
        check("pwr_sleep", DEEP_SLEEP, 1'b0);
        check("pwr_wel", WRITE_ENABLE_LATCH, 1'b0);
        check("pwr_inhibit", WRITE_INHIBIT, 1'b1);
        finish_test();
    end
endmodule
